// ---- rtl/pfs_cfg.svh ----
// Register map, field positions and codes of the programmable filter stage.
// Assumes a 16-bit Avalon byte address with one 32-bit word per register.
`ifndef PFS_CFG_SVH
`define PFS_CFG_SVH

// Register indices; byte address is four times the index
`define PFS_IDX_XFER 14'h000F
`define PFS_IDX_ARR 14'h0DF8
`define PFS_IDX_GAIN 14'h0DF9
`define PFS_IDX_XCOEF 14'h0E00
`define PFS_IDX_YCOEF 14'h0F00
`define PFS_COEF_IDX_MSB 13
`define PFS_COEF_IDX_LSB 7

// Field positions
`define PFS_XFER_BIT 0
`define PFS_ARR_MSB 2
`define PFS_ARR_LSB 0
`define PFS_YG_MSB 6
`define PFS_YG_LSB 4
`define PFS_XG_MSB 2
`define PFS_XG_LSB 0

// Reset values
`define PFS_ARR_RST 3'h0
`define PFS_GAIN_RST 3'h0

// Arrangement codes
`define PFS_ARR_BYPASS 3'h0
`define PFS_ARR_XONLY 3'h1
`define PFS_ARR_JOIN 3'h2
`define PFS_ARR_CASC 3'h4
`define PFS_ARR_REAL96 3'h7

// Gain codes
`define PFS_G_0DB 3'h0
`define PFS_G_P6DB 3'h1
`define PFS_G_P12DB 3'h2
`define PFS_G_M12DB 3'h6
`define PFS_G_M6DB 3'h7

// Coefficient store: X bank then Y bank, 128 words each
`define PFS_COEF_WORDS 9'h100

`endif

// ---- rtl/pfs_coef_mem.sv ----
// Coefficient memory, 256 x 8, one write port and one registered read port.
// Assumes both ports on the same clock; contents are not reset.
`timescale 1ns/1ps
`default_nettype none

module pfs_coef_mem
  import pfs_pkg::*;
(
  input wire logic mclk,
  input wire logic we,
  input wire pfs_pkg::pfs_caddr_t waddr,
  input wire pfs_pkg::pfs_coef_t wdata,
  input wire pfs_pkg::pfs_caddr_t raddr,
  output pfs_pkg::pfs_coef_t rdata_q
);
  pfs_coef_t mem [0:255];

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule

`default_nettype wire

// ---- rtl/pfs_gain_shift.sv ----
// Gain or loss step applied to one filter result, with saturation.
// Assumes a 16-bit signed result; reserved codes pass the value unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "pfs_cfg.svh"

module pfs_gain_shift
  import pfs_pkg::*;
(
  input wire pfs_pkg::pfs_sample_t din,
  input wire pfs_pkg::pfs_code_t code,
  output pfs_pkg::pfs_sample_t dout
);
  wire signed [17:0] ext = {{2{din[15]}}, din};
  wire signed [17:0] scaled =
    (code == `PFS_G_P6DB) ? (ext <<< 1) :
    (code == `PFS_G_P12DB) ? (ext <<< 2) :
    (code == `PFS_G_M12DB) ? (ext >>> 2) :
    (code == `PFS_G_M6DB) ? (ext >>> 1) : ext;
  wire over_hi = !scaled[17] && (scaled[16:15] != 2'b00);
  wire over_lo = scaled[17] && (scaled[16:15] != 2'b11);
  assign dout = over_hi ? 16'sh7FFF : over_lo ? 16'sh8000 : scaled[15:0];
endmodule

`default_nettype wire

// ---- rtl/pfs_pkg.sv ----
// Types shared by the programmable filter stage.
// Assumes pfs_cfg.svh is on the include path.
`include "pfs_cfg.svh"

package pfs_pkg;
  typedef logic signed [15:0] pfs_sample_t;
  typedef logic [2:0] pfs_code_t;
  typedef logic [7:0] pfs_coef_t;
  typedef logic [7:0] pfs_caddr_t;
  typedef enum logic [2:0] {
    PFS_ST_IDLE = 3'b001,
    PFS_ST_FETCH = 3'b010,
    PFS_ST_ANSWER = 3'b100
  } pfs_bus_state_t;
endpackage

// ---- rtl/pfs_stage.sv ----
// Programmable filter stage control: arrangement, gains, coefficient transfer.
// Assumes an Avalon-MM master on mclk and external filter arithmetic on mclk.
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pfs_cfg.svh"

module pfs_stage
  import pfs_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire pfs_pkg::pfs_sample_t sample_in,
  input wire logic sample_in_valid,
  input wire pfs_pkg::pfs_sample_t fir_x_result,
  input wire pfs_pkg::pfs_sample_t fir_y_result,
  input wire pfs_pkg::pfs_caddr_t coef_rd_addr,
  output pfs_pkg::pfs_coef_t coef_rd_data,
  output pfs_pkg::pfs_code_t fir_arrangement,
  output pfs_pkg::pfs_sample_t cascade_feed,
  output pfs_pkg::pfs_sample_t sample_out,
  output logic sample_out_valid,
  output logic xfer_busy
);
  import pfs_pkg::*;

  pfs_bus_state_t st_q, st_d;
  pfs_code_t arr_q, ygain_q, xgain_q;
  logic [31:0] rdata_q;
  logic wait_q;
  logic busy_q;
  logic [8:0] cp_cnt_q;
  logic cp_wv_q;
  pfs_caddr_t cp_wa_q;
  pfs_sample_t out_q, feed_q;
  logic out_v_q;
  pfs_coef_t stg_rdata;

  // Bus decode
  wire [13:0] idx = avs_address[15:2];
  wire req = avs_read || avs_write;
  wire hit_xfer = (idx == `PFS_IDX_XFER);
  wire hit_arr = (idx == `PFS_IDX_ARR);
  wire hit_gain = (idx == `PFS_IDX_GAIN);
  wire hit_xc = (idx[`PFS_COEF_IDX_MSB:`PFS_COEF_IDX_LSB] ==
    7'(`PFS_IDX_XCOEF >> `PFS_COEF_IDX_LSB));
  wire hit_yc = (idx[`PFS_COEF_IDX_MSB:`PFS_COEF_IDX_LSB] ==
    7'(`PFS_IDX_YCOEF >> `PFS_COEF_IDX_LSB));
  wire hit_coef = hit_xc || hit_yc;
  wire [7:0] bus_caddr = {hit_yc, idx[6:0]};
  wire wr_now = (st_q == PFS_ST_ANSWER) && avs_write && avs_byteenable[0];

  // Bus state sequence; no new request taken while a transfer runs
  always_comb begin
    st_d = st_q;
    case (st_q)
      PFS_ST_IDLE: begin
        if (req && !busy_q) begin
          st_d = PFS_ST_FETCH;
        end
      end
      PFS_ST_FETCH: begin
        st_d = PFS_ST_ANSWER;
      end
      PFS_ST_ANSWER: begin
        st_d = PFS_ST_IDLE;
      end
      default: begin
        st_d = PFS_ST_IDLE;
      end
    endcase
  end

  // Read mux; reserved bits and unmapped words read zero
  wire [31:0] rd_mux =
    hit_xfer ? {31'h0, busy_q} :
    hit_arr ? {29'h0, arr_q} :
    hit_gain ? {25'h0, ygain_q, 1'b0, xgain_q} :
    hit_coef ? {24'h0, stg_rdata} : 32'h0;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= PFS_ST_IDLE;
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      st_q <= st_d;
      wait_q <= (st_q != PFS_ST_FETCH);
      if (st_q == PFS_ST_FETCH) begin
        rdata_q <= avs_read ? rd_mux : 32'h0;
      end
    end
  end

  // Only defined field bits are stored
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      arr_q <= `PFS_ARR_RST;
      ygain_q <= `PFS_GAIN_RST;
      xgain_q <= `PFS_GAIN_RST;
    end else if (wr_now && hit_arr) begin
      arr_q <= avs_writedata[`PFS_ARR_MSB:`PFS_ARR_LSB];
    end else if (wr_now && hit_gain) begin
      ygain_q <= avs_writedata[`PFS_YG_MSB:`PFS_YG_LSB];
      xgain_q <= avs_writedata[`PFS_XG_MSB:`PFS_XG_LSB];
    end
  end

  // Coefficient transfer: copy staging store into the active store
  wire xfer_go = wr_now && hit_xfer && avs_writedata[`PFS_XFER_BIT];
  wire cp_last = (cp_cnt_q == `PFS_COEF_WORDS);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
      cp_cnt_q <= 9'h000;
      cp_wv_q <= 1'b0;
      cp_wa_q <= 8'h00;
    end else begin
      cp_wv_q <= busy_q && !cp_last;
      cp_wa_q <= cp_cnt_q[7:0];
      if (xfer_go) begin
        busy_q <= 1'b1;
        cp_cnt_q <= 9'h000;
      end else if (busy_q && cp_last) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        cp_cnt_q <= cp_cnt_q + 9'h001;
      end
    end
  end

  wire [7:0] stg_raddr = busy_q ? cp_cnt_q[7:0] : bus_caddr;

  pfs_coef_mem u_staging (
    .mclk(mclk),
    .we(wr_now && hit_coef),
    .waddr(bus_caddr),
    .wdata(avs_writedata[7:0]),
    .raddr(stg_raddr),
    .rdata_q(stg_rdata)
  );

  pfs_coef_mem u_active (
    .mclk(mclk),
    .we(cp_wv_q),
    .waddr(cp_wa_q),
    .wdata(stg_rdata),
    .raddr(coef_rd_addr),
    .rdata_q(coef_rd_data)
  );

  // Sample path
  pfs_sample_t gx, gy;

  pfs_gain_shift u_xgain (
    .din(fir_x_result),
    .code(xgain_q),
    .dout(gx)
  );

  pfs_gain_shift u_ygain (
    .din(fir_y_result),
    .code(ygain_q),
    .dout(gy)
  );

  wire is_x = (arr_q == `PFS_ARR_XONLY);
  wire is_join = (arr_q == `PFS_ARR_JOIN) || (arr_q == `PFS_ARR_REAL96);
  wire is_casc = (arr_q == `PFS_ARR_CASC);
  wire signed [16:0] sum = {gx[15], gx} + {gy[15], gy};
  wire [15:0] sum_sat = (sum[16] == sum[15]) ? sum[15:0] :
    (sum[16] ? 16'h8000 : 16'h7FFF);
  wire [15:0] out_d =
    is_x ? gx :
    is_join ? sum_sat :
    is_casc ? gy :
    sample_in;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      out_q <= 16'h0000;
      feed_q <= 16'h0000;
      out_v_q <= 1'b0;
    end else begin
      out_v_q <= sample_in_valid;
      if (sample_in_valid) begin
        out_q <= out_d;
        feed_q <= gx;
      end
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign fir_arrangement = arr_q;
  assign cascade_feed = feed_q;
  assign sample_out = out_q;
  assign sample_out_valid = out_v_q;
  assign xfer_busy = busy_q;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // Results small enough that no gain step or sum saturates
  wire small_x = (fir_x_result[15:12] == 4'h0) || (fir_x_result[15:12] == 4'hF);
  wire small_y = (fir_y_result[15:12] == 4'h0) || (fir_y_result[15:12] == 4'hF);

  bypass_pass_a: assert property (
    (arr_q == `PFS_ARR_BYPASS) && sample_in_valid |=> sample_out == $past(sample_in))
    else $error("bypass output differs from input");
  xonly_gain_a: assert property (
    is_x && xgain_q == `PFS_G_P6DB && small_x && sample_in_valid
    |=> sample_out == $past(fir_x_result) * 2)
    else $error("x only +6 dB output wrong");
  join_sum_a: assert property (
    is_join && xgain_q == `PFS_G_0DB && ygain_q == `PFS_G_0DB && small_x && small_y
    && sample_in_valid |=> sample_out == $past(fir_x_result) + $past(fir_y_result))
    else $error("joined filter output wrong");
  cascade_feed_a: assert property (
    is_casc && xgain_q == `PFS_G_0DB && sample_in_valid
    |=> cascade_feed == $past(fir_x_result) && sample_out == $past(gy))
    else $error("cascade feed wrong");
  ygain_up_a: assert property (
    is_casc && ygain_q == `PFS_G_P12DB && small_y && sample_in_valid
    |=> sample_out == $past(fir_y_result) * 4)
    else $error("y +12 dB output wrong");
  ygain_loss_a: assert property (
    is_casc && ygain_q == `PFS_G_M12DB && sample_in_valid
    |=> sample_out == ($past(fir_y_result) >>> 2))
    else $error("y -12 dB output wrong");
  active_hold_a: assert property (
    !busy_q && !$past(busy_q) |-> !cp_wv_q)
    else $error("active store written outside transfer");
  xfer_bound_a: assert property (
    $rose(busy_q) |-> ##256 busy_q ##1 !busy_q)
    else $error("transfer length wrong");
  xonly_loss_a: assert property (
    is_x && xgain_q == `PFS_G_M6DB && sample_in_valid
    |=> sample_out == ($past(fir_x_result) >>> 1))
    else $error("x only -6 dB output wrong");
  ygain_double_a: assert property (
    is_casc && ygain_q == `PFS_G_P6DB && small_y && sample_in_valid
    |=> sample_out == $past(fir_y_result) * 2)
    else $error("y +6 dB output wrong");
  busy_refuse_a: assert property (
    busy_q |-> avs_waitrequest)
    else $error("bus answered during transfer");
  out_strobe_a: assert property (
    sample_out_valid == $past(sample_in_valid))
    else $error("output strobe not one cycle after input");
  reserved_zero_a: assert property (
    st_q == PFS_ST_ANSWER && avs_read && (hit_arr || hit_gain)
    |-> avs_readdata[31:7] == 25'h0 && (hit_gain || avs_readdata[6:3] == 4'h0)
    && (!hit_gain || avs_readdata[3] == 1'b0))
    else $error("reserved bits read nonzero");
  wait_pulse_a: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");

  xfer_done_c: cover property ($fell(busy_q));
  cascade_run_c: cover property (is_casc && sample_in_valid);
  join_run_c: cover property (is_join && sample_in_valid);
  xonly_run_c: cover property (is_x && sample_in_valid);
  coef_read_c: cover property (st_q == PFS_ST_ANSWER && avs_read && hit_coef);
endmodule

`default_nettype wire

// ---- testbench/pfs_stage_tb.sv ----
// Self-checking bench for the programmable filter stage control block.
// Assumes the design files and pfs_cfg.svh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "pfs_cfg.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
  $display("MISMATCH at %0t: got %h expected %h", $time, (got), (exp)); end end

module pfs_stage_tb;
  import pfs_pkg::*;
  localparam logic [15:0] A_XFER = {`PFS_IDX_XFER, 2'b00};
  localparam logic [15:0] A_ARR = {`PFS_IDX_ARR, 2'b00};
  localparam logic [15:0] A_GAIN = {`PFS_IDX_GAIN, 2'b00};
  localparam logic [15:0] A_XCOEF = {`PFS_IDX_XCOEF, 2'b00};
  localparam logic [15:0] A_YCOEF = {`PFS_IDX_YCOEF, 2'b00};
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  pfs_sample_t sample_in = '0;
  logic sample_in_valid = 1'b0;
  pfs_sample_t fir_x_result = '0;
  pfs_sample_t fir_y_result = '0;
  pfs_caddr_t coef_rd_addr = '0;
  pfs_coef_t coef_rd_data;
  pfs_code_t fir_arrangement;
  pfs_sample_t cascade_feed;
  pfs_sample_t sample_out;
  logic sample_out_valid;
  logic xfer_busy;
  int num_errors = 0;
  int tests_run = 0;
  logic [31:0] rd;
  pfs_code_t codes [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  pfs_sample_t vx = 16'h0120;
  pfs_sample_t vy = 16'hFCC0;

  always #20 mclk = ~mclk;

  pfs_stage dut (.mclk(mclk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sample_in(sample_in),
    .sample_in_valid(sample_in_valid), .fir_x_result(fir_x_result),
    .fir_y_result(fir_y_result), .coef_rd_addr(coef_rd_addr),
    .coef_rd_data(coef_rd_data), .fir_arrangement(fir_arrangement),
    .cascade_feed(cascade_feed), .sample_out(sample_out),
    .sample_out_valid(sample_out_valid), .xfer_busy(xfer_busy));

  function automatic pfs_sample_t sat(input logic signed [17:0] w);
    if (w > 18'sd32767) return 16'h7FFF;
    if (w < -18'sd32768) return 16'h8000;
    return w[15:0];
  endfunction

  // Expected gain step: shifts by the code, then clamps to 16 bits
  function automatic pfs_sample_t gw(input pfs_sample_t v, input pfs_code_t c);
    logic signed [17:0] w;
    w = v;
    case (c)
      3'h1: w = w <<< 1;
      3'h2: w = w <<< 2;
      3'h6: w = w >>> 2;
      3'h7: w = w >>> 1;
      default: w = w;
    endcase
    return sat(w);
  endfunction

  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 400);
    `CHK(avs_waitrequest, 1'b0)
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d}, 4'hF);
  endtask

  task automatic rdc(input logic [15:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    `CHK(rd, e)
  endtask

  task automatic smp(input pfs_sample_t s, input pfs_sample_t e);
    @(posedge mclk);
    sample_in <= s;
    fir_x_result <= vx;
    fir_y_result <= vy;
    sample_in_valid <= 1'b1;
    @(posedge mclk);
    sample_in_valid <= 1'b0;
    @(negedge mclk);
    `CHK(sample_out_valid, 1'b1)
    `CHK(sample_out, e)
  endtask

  task automatic crd(input pfs_caddr_t a, input pfs_coef_t e);
    @(posedge mclk);
    coef_rd_addr <= a;
    @(posedge mclk);
    @(negedge mclk);
    `CHK(coef_rd_data, e)
  endtask

  // Transfer, then a read of the busy flag that must wait until the copy ends
  task automatic xfer();
    wr(A_XFER, 8'h01);
    @(negedge mclk);
    `CHK(xfer_busy, 1'b1)
    rdc(A_XFER, 32'h0);
    `CHK(xfer_busy, 1'b0)
  endtask

  task automatic summarize();
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #400000;
    num_errors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    rdc(A_ARR, 32'h0);
    rdc(A_GAIN, 32'h0);
    wr(A_ARR, 8'hFF);
    rdc(A_ARR, 32'h7);
    wr(A_GAIN, 8'hFF);
    rdc(A_GAIN, 32'h77);
    bus(1'b1, A_ARR, 32'h5, 4'h0);
    rdc(A_ARR, 32'h7);
    rdc(16'h0100, 32'h0);
    wr(A_ARR, 8'h00);
    smp(16'h1234, 16'h1234);
    `CHK(fir_arrangement, 3'h0)
    wr(A_ARR, 8'h03);
    smp(16'h0567, 16'h0567);
    foreach (codes[i]) begin
      wr(A_GAIN, {1'b0, codes[i], 1'b0, codes[i]});
      wr(A_ARR, 8'h01);
      smp(16'h0001, gw(vx, codes[i]));
      wr(A_ARR, 8'h04);
      smp(16'h0001, gw(vy, codes[i]));
      `CHK(cascade_feed, gw(vx, codes[i]))
      `CHK(fir_arrangement, 3'h4)
      wr(A_ARR, 8'h02);
      smp(16'h0001, sat(gw(vx, codes[i]) + gw(vy, codes[i])));
    end
    wr(A_GAIN, 8'h71);
    wr(A_ARR, 8'h02);
    smp(16'h0001, sat(gw(vx, 3'h1) + gw(vy, 3'h7)));
    wr(A_ARR, 8'hF7);
    smp(16'h0001, sat(gw(vx, 3'h1) + gw(vy, 3'h7)));
    `CHK(fir_arrangement, 3'h7)
    vx = 16'h3000;
    vy = 16'h3000;
    wr(A_GAIN, 8'h22);
    smp(16'h0001, 16'h7FFF);
    wr(A_XCOEF, 8'h5A);
    wr(A_YCOEF + 16'h0004, 8'h3C);
    xfer();
    crd(8'h00, 8'h5A);
    crd(8'h81, 8'h3C);
    wr(A_XCOEF, 8'hA5);
    crd(8'h00, 8'h5A);
    rdc(A_XCOEF, 32'hA5);
    xfer();
    crd(8'h00, 8'hA5);
    summarize();
  end
endmodule

`undef CHK
`default_nettype wire
